// ---- design/ido_core.sv ----
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Direct mode reaches any of the lowest 256 locations with an opcode and one address byte.
// - In direct mode the byte after the opcode is the low byte of the effective address.
// - In direct mode the high address byte is forced to zero and never fetched.
// - A direct form takes one program byte and one bus cycle fewer than its extended form.
// - Bit-test branches are opcode, direct address, then relative displacement.
// - Direct index-pair compare, store and load use address for high byte and address+1 for low.
// - Add-signed-to-stack-pointer adds the sign-extended immediate byte to the stack pointer.
// - Add-signed-to-index adds the sign-extended immediate byte to the 16-bit index pair.
// - Accumulator and low index compare-and-branch take the branch when equal to the immediate.
// - The 16-bit index pair can be loaded from and compared with an immediate operand.
// - Memory compare-and-branch compares a direct operand with the accumulator, branches if equal.
// - Decrement-and-branch decrements the direct byte, writes it back, branches if not zero.
// - Arithmetic and logical shift left of memory are one opcode with one result.
// - Immediate operands follow the opcode: two bytes for the index-pair load and compare, one byte otherwise.
// - Immediate index-pair instructions carry two bytes of data after the opcode.
module ido_core (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // memory bus, read data valid one cycle after its address
  input wire logic [7:0] mem_rdata_i,
  output var ido_pkg::ido_bus_s mem_bus_o,
  // architectural state
  output var ido_pkg::ido_regs_s regs_o,
  output logic instr_done_o
);

  ido_pkg::ido_state_e state;
  ido_pkg::ido_state_e next_state;
  ido_pkg::ido_dec_s dec;
  logic [7:0] opcode;
  logic [7:0] byte1;
  logic [7:0] byte2;
  logic [7:0] mem1;
  logic [7:0] mem2;
  logic [15:0] eff_addr;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] hx;
  logic [7:0] acc;
  logic zero;
  logic carry;
  logic [7:0] wbyte;
  logic take_branch;
  logic [7:0] alu_res;
  logic [16:0] cmp16;
  logic [15:0] operand16;
  logic tested_bit;

  // sign-extend an 8-bit immediate or displacement
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction : sext8

  // instruction length and bus shape from the opcode
  function automatic ido_pkg::ido_dec_s decode(input logic [7:0] op);
    ido_pkg::ido_dec_s d;
    d = '0;
    d.known = 1'b1;
    if (op[7:4] == ido_pkg::OPC_BITBR_HI)
    begin
      d.two_bytes = 1'b1;
      d.mem_rd = 1'b1;
    end
    else
    begin
      case (op)
        ido_pkg::OPC_LDA_IMM, ido_pkg::OPC_LDX_IMM,
        ido_pkg::OPC_ADD_SP_IMM, ido_pkg::OPC_ADD_IDX_IMM: d.known = 1'b1;
        ido_pkg::OPC_CMP_ACC_BR_IMM, ido_pkg::OPC_CMP_XLO_BR_IMM: d.two_bytes = 1'b1;
        ido_pkg::OPC_CMP_PAIR_IMM, ido_pkg::OPC_LOAD_PAIR_IMM:
        begin
          d.two_bytes = 1'b1;
          d.imm16 = 1'b1;
        end
        ido_pkg::OPC_LDA_DIR: d.mem_rd = 1'b1;
        ido_pkg::OPC_SHIFT_LEFT_DIR:
        begin
          d.mem_rd = 1'b1;
          d.mem_wr = 1'b1;
        end
        ido_pkg::OPC_LDA_EXT:
        begin
          d.two_bytes = 1'b1;
          d.ext = 1'b1;
          d.mem_rd = 1'b1;
        end
        ido_pkg::OPC_CMP_MEM_BR_DIR: begin d.two_bytes = 1'b1; d.mem_rd = 1'b1; end
        ido_pkg::OPC_DEC_BR_DIR:
        begin
          d.two_bytes = 1'b1;
          d.mem_rd = 1'b1;
          d.mem_wr = 1'b1;
        end
        ido_pkg::OPC_CMP_PAIR_DIR, ido_pkg::OPC_LOAD_PAIR_DIR:
        begin
          d.mem_rd = 1'b1;
          d.mem16 = 1'b1;
        end
        ido_pkg::OPC_STORE_PAIR_DIR: d.mem_wr = 1'b1;
        default: d.known = 1'b0;
      endcase
    end
    decode = d;
  endfunction : decode

  // in OPC the opcode is still on the read bus, later it is latched
  assign dec = decode((state == ido_pkg::S_OPC) ? mem_rdata_i : opcode);

  // sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      ido_pkg::S_FETCH: next_state = ido_pkg::S_OPC;
      ido_pkg::S_OPC: next_state = dec.known ? ido_pkg::S_B1 : ido_pkg::S_FETCH;
      ido_pkg::S_B1:
        if (dec.two_bytes)
          next_state = ido_pkg::S_B2;
        else if (dec.mem_rd)
          next_state = ido_pkg::S_M1;
        else
          next_state = ido_pkg::S_EXEC;
      ido_pkg::S_B2: next_state = dec.mem_rd ? ido_pkg::S_M1 : ido_pkg::S_EXEC;
      ido_pkg::S_M1: next_state = dec.mem16 ? ido_pkg::S_M2 : ido_pkg::S_EXEC;
      ido_pkg::S_M2: next_state = ido_pkg::S_EXEC;
      ido_pkg::S_EXEC: next_state = dec.mem_wr ? ido_pkg::S_W1 : ido_pkg::S_FETCH;
      ido_pkg::S_W1:
        next_state = (opcode == ido_pkg::OPC_STORE_PAIR_DIR) ? ido_pkg::S_W2 : ido_pkg::S_FETCH;
      ido_pkg::S_W2: next_state = ido_pkg::S_FETCH;
      default: next_state = ido_pkg::S_FETCH;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= ido_pkg::S_FETCH;
    else
      state <= next_state;
  end

  // program counter: one step per program byte read, then the branch
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pc <= ido_pkg::RESET_PC;
    else if (state == ido_pkg::S_FETCH || state == ido_pkg::S_OPC && dec.known)
      pc <= pc + ido_pkg::ADDR_STEP;
    else if (state == ido_pkg::S_B1 && dec.two_bytes)
      pc <= pc + ido_pkg::ADDR_STEP;
    else if (state == ido_pkg::S_EXEC && take_branch)
      pc <= pc + sext8(byte2); // displacement counts from the next opcode
  end

  // instruction bytes, operand data and effective address
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      opcode <= 8'h00;
      byte1 <= 8'h00;
      byte2 <= 8'h00;
      mem1 <= 8'h00;
      mem2 <= 8'h00;
      eff_addr <= 16'h0000;
    end
    else
    begin
      unique case (state)
        ido_pkg::S_OPC: opcode <= mem_rdata_i;
        ido_pkg::S_B1:
        begin
          byte1 <= mem_rdata_i;
          eff_addr <= {ido_pkg::DIRECT_PAGE, mem_rdata_i};
        end
        ido_pkg::S_B2:
        begin
          byte2 <= mem_rdata_i;
          if (dec.ext)
            eff_addr <= {byte1, mem_rdata_i};
        end
        ido_pkg::S_M1: mem1 <= mem_rdata_i;
        ido_pkg::S_M2: mem2 <= mem_rdata_i;
        default: mem2 <= mem2;
      endcase
    end
  end

  // execute datapath; the bit-branch displacement is byte2, as for the others
  always_comb
  begin
    operand16 = dec.imm16 ? {byte1, byte2} : {mem1, mem2};
    cmp16 = {1'b0, hx} - {1'b0, operand16};
    tested_bit = mem1[opcode[3:1]];
    alu_res = 8'h00;
    take_branch = 1'b0;
    if (opcode[7:4] == ido_pkg::OPC_BITBR_HI)
      take_branch = tested_bit ^ opcode[0];
    else
    begin
      case (opcode)
        ido_pkg::OPC_CMP_ACC_BR_IMM: take_branch = (acc == byte1);
        ido_pkg::OPC_CMP_XLO_BR_IMM: take_branch = (hx[7:0] == byte1);
        ido_pkg::OPC_CMP_MEM_BR_DIR: take_branch = (acc == mem1);
        ido_pkg::OPC_DEC_BR_DIR:
        begin
          alu_res = mem1 - ido_pkg::BYTE_ONE;
          take_branch = (alu_res != 8'h00);
        end
        ido_pkg::OPC_SHIFT_LEFT_DIR: alu_res = {mem1[6:0], 1'b0};
        default: alu_res = 8'h00;
      endcase
    end
  end

  // programmer-visible registers, updated once per instruction
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc <= 8'h00;
      hx <= 16'h0000;
      sp <= ido_pkg::RESET_SP;
      zero <= 1'b0;
      carry <= 1'b0;
    end
    else if (state == ido_pkg::S_EXEC)
    begin
      case (opcode)
        ido_pkg::OPC_LDA_IMM: acc <= byte1;
        ido_pkg::OPC_LDA_DIR, ido_pkg::OPC_LDA_EXT: acc <= mem1;
        ido_pkg::OPC_LDX_IMM: hx[7:0] <= byte1;
        ido_pkg::OPC_ADD_SP_IMM: sp <= sp + sext8(byte1);
        ido_pkg::OPC_ADD_IDX_IMM: hx <= hx + sext8(byte1);
        ido_pkg::OPC_LOAD_PAIR_IMM, ido_pkg::OPC_LOAD_PAIR_DIR:
        begin
          hx <= operand16;
          zero <= (operand16 == 16'h0000);
        end
        ido_pkg::OPC_CMP_PAIR_IMM, ido_pkg::OPC_CMP_PAIR_DIR:
        begin
          zero <= (cmp16[15:0] == 16'h0000);
          carry <= cmp16[16];
        end
        ido_pkg::OPC_DEC_BR_DIR: zero <= zero; // flags untouched by the loop counter
        ido_pkg::OPC_SHIFT_LEFT_DIR:
        begin
          carry <= mem1[7];
          zero <= (alu_res == 8'h00);
        end
        default:
          if (opcode[7:4] == ido_pkg::OPC_BITBR_HI)
            carry <= tested_bit;
      endcase
    end
  end

  // write data is registered so the bus sees a clean byte
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wbyte <= 8'h00;
    else if (state == ido_pkg::S_EXEC)
      wbyte <= (opcode == ido_pkg::OPC_STORE_PAIR_DIR) ? hx[15:8] : alu_res;
    else if (state == ido_pkg::S_W1)
      wbyte <= hx[7:0]; // low byte goes to address + 1
  end

  // bus drive; B1 steers a direct address and B2 an extended address from the byte on the bus
  always_comb
  begin
    mem_bus_o = '0;
    mem_bus_o.wdata = wbyte;
    unique case (state)
      ido_pkg::S_FETCH, ido_pkg::S_OPC:
      begin
        mem_bus_o.addr = pc;
        mem_bus_o.re = (state == ido_pkg::S_FETCH) || dec.known;
      end
      ido_pkg::S_B1:
      begin
        mem_bus_o.re = dec.two_bytes || dec.mem_rd;
        mem_bus_o.addr = dec.two_bytes ? pc : {ido_pkg::DIRECT_PAGE, mem_rdata_i};
      end
      ido_pkg::S_B2:
      begin
        mem_bus_o.re = dec.mem_rd;
        mem_bus_o.addr = dec.ext ? {byte1, mem_rdata_i} : eff_addr;
      end
      ido_pkg::S_M1:
      begin
        mem_bus_o.re = dec.mem16;
        mem_bus_o.addr = eff_addr + ido_pkg::ADDR_STEP;
      end
      ido_pkg::S_W1:
      begin
        mem_bus_o.we = 1'b1;
        mem_bus_o.addr = eff_addr;
      end
      ido_pkg::S_W2:
      begin
        mem_bus_o.we = 1'b1;
        mem_bus_o.addr = eff_addr + ido_pkg::ADDR_STEP;
      end
      default: mem_bus_o.addr = eff_addr;
    endcase
  end

  assign regs_o = '{acc: acc, hx: hx, sp: sp, pc: pc, zero: zero, carry: carry};
  assign instr_done_o = (state != ido_pkg::S_FETCH) && (next_state == ido_pkg::S_FETCH);

endmodule : ido_core

`default_nettype wire

// ---- design/ido_pkg.sv ----
package ido_pkg;

  // opcodes handled by this operand-fetch core
  localparam logic [7:0] OPC_LDA_IMM = 8'hA6;
  localparam logic [7:0] OPC_LDX_IMM = 8'hAE;
  localparam logic [7:0] OPC_ADD_SP_IMM = 8'hA7;
  localparam logic [7:0] OPC_ADD_IDX_IMM = 8'hAF;
  localparam logic [7:0] OPC_CMP_ACC_BR_IMM = 8'h41;
  localparam logic [7:0] OPC_CMP_XLO_BR_IMM = 8'h51;
  localparam logic [7:0] OPC_CMP_PAIR_IMM = 8'h65;
  localparam logic [7:0] OPC_LOAD_PAIR_IMM = 8'h45;
  localparam logic [7:0] OPC_LDA_DIR = 8'hB6;
  localparam logic [7:0] OPC_LDA_EXT = 8'hC6;
  localparam logic [7:0] OPC_CMP_MEM_BR_DIR = 8'h31;
  localparam logic [7:0] OPC_DEC_BR_DIR = 8'h3B;
  localparam logic [7:0] OPC_SHIFT_LEFT_DIR = 8'h38;
  localparam logic [7:0] OPC_CMP_PAIR_DIR = 8'h75;
  localparam logic [7:0] OPC_STORE_PAIR_DIR = 8'h35;
  localparam logic [7:0] OPC_LOAD_PAIR_DIR = 8'h55;
  // bit-test branches occupy opcodes 0x00..0x0F
  localparam logic [3:0] OPC_BITBR_HI = 4'h0;

  // direct page high byte and reset values
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [15:0] RESET_PC = 16'h0100;
  localparam logic [15:0] RESET_SP = 16'h00FF;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  typedef enum logic [3:0] {
    S_FETCH = 4'h0,
    S_OPC = 4'h1,
    S_B1 = 4'h2,
    S_B2 = 4'h3,
    S_M1 = 4'h4,
    S_M2 = 4'h5,
    S_EXEC = 4'h6,
    S_W1 = 4'h7,
    S_W2 = 4'h8
  } ido_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ido_bus_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic zero;
    logic carry;
  } ido_regs_s;

  typedef struct packed {
    logic known;
    logic two_bytes;
    logic imm16;
    logic ext;
    logic mem_rd;
    logic mem16;
    logic mem_wr;
  } ido_dec_s;

endpackage : ido_pkg

// ---- tb/ido_core_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module ido_core_bench;
  logic sys_clk_i;
  logic reset_n_i;
  logic [7:0] rdata;
  ido_pkg::ido_bus_s bus;
  ido_pkg::ido_regs_s regs;
  logic done;
  logic [15:0] cur;
  int n_fail;
  int total_checks;
  // core against a never-stalling memory
  ido_core ido_core_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .mem_rdata_i(rdata),
    .mem_bus_o(bus), .regs_o(regs), .instr_done_o(done));
  ido_mem_model ido_mem_model_i (.sys_clk_i(sys_clk_i), .bus_i(bus), .rdata_o(rdata));
  // 40 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task complete_run;
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task put(input logic [15:0] a, input logic [7:0] d);
    ido_mem_model_i.mem[a] = d;
  endtask : put
  // program bytes go at the cursor, first byte in the top of the low len bytes of code
  task emit(input int len, input logic [23:0] code);
    for (int k = 0; k < len; k++)
      put(cur + 16'(k), code[8*(len-1-k) +: 8]);
    cur = cur + 16'(len);
  endtask : emit
  // bounded wait for the done pulse, then length and next pc
  task run(input int cyc, input logic [15:0] skip);
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk_i);
      n++;
    end
    while (done !== 1'b1 && n < 20);
    if (done !== 1'b1)
    begin
      n_fail++;
      complete_run();
    end
    @(posedge sys_clk_i);
    #1;
    cur = cur + skip;
    chk(16'(n), 16'(cyc));
    chk(regs.pc, cur);
  endtask : run
  task t_pair_imm;
    emit(3, 24'h451234);
    run(5, 16'h0000);
    chk(regs.hx, 16'h1234);
    emit(3, 24'h651234);
    run(5, 16'h0000);
    chk({15'h0000, regs.zero}, 16'h0001);
  endtask : t_pair_imm
  task t_signed;
    emit(2, 24'h00AFFE);
    run(4, 16'h0000);
    chk(regs.hx, 16'h1232);
    emit(2, 24'h00A780);
    run(4, 16'h0000);
    chk(regs.sp, 16'h007F);
  endtask : t_signed
  task t_pair_dir;
    emit(2, 24'h003550);
    run(6, 16'h0000);
    chk({ido_mem_model_i.mem[16'h0050], ido_mem_model_i.mem[16'h0051]}, 16'h1232);
    put(16'h0070, 8'hAB);
    put(16'h0071, 8'hCD);
    emit(2, 24'h005570);
    run(6, 16'h0000);
    chk(regs.hx, 16'hABCD);
  endtask : t_pair_dir
  task t_dir_ext;
    put(16'h00FF, 8'h5A);
    put(16'h10FF, 8'hA5);
    emit(2, 24'h00B6FF);
    run(5, 16'h0000);
    chk({8'h00, regs.acc}, 16'h005A);
    emit(3, 24'hC610FF);
    run(6, 16'h0000);
    chk({8'h00, regs.acc}, 16'h00A5);
  endtask : t_dir_ext
  task t_cmp_br;
    emit(2, 24'h00A65A);
    run(4, 16'h0000);
    emit(3, 24'h415A02);
    run(5, 16'h0002);
    emit(3, 24'h51CC04);
    run(5, 16'h0000);
    put(16'h0062, 8'h5A);
    emit(3, 24'h316203);
    run(6, 16'h0003);
  endtask : t_cmp_br
  task t_modify;
    put(16'h0060, 8'h02);
    emit(3, 24'h3B6002);
    run(7, 16'h0002);
    emit(3, 24'h3B6002);
    run(7, 16'h0000);
    chk({8'h00, ido_mem_model_i.mem[16'h0060]}, 16'h0000);
    put(16'h0061, 8'h81);
    emit(2, 24'h003861);
    run(6, 16'h0000);
    chk({7'h00, regs.carry, ido_mem_model_i.mem[16'h0061]}, 16'h0102);
  endtask : t_modify
  task t_bit_br;
    emit(3, 24'h026104);
    run(6, 16'h0004);
    emit(3, 24'h036104);
    run(6, 16'h0000);
    chk({15'h0000, regs.carry}, 16'h0001);
    emit(1, 24'h00009D);
    run(2, 16'h0000);
  endtask : t_bit_br
  // reset held 20 cycles, released on a rising edge
  initial
  begin
    reset_n_i = 1'b0;
    n_fail = 0;
    total_checks = 0;
    cur = 16'h0100;
    repeat (20) @(posedge sys_clk_i);
    chk(regs.pc, cur);
    reset_n_i <= 1'b1;
    t_pair_imm();
    t_signed();
    t_pair_dir();
    t_dir_ext();
    t_cmp_br();
    t_modify();
    t_bit_br();
    complete_run();
  end
endmodule : ido_core_bench
`default_nettype wire

// ---- tb/ido_core_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module ido_core_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // watched ports
  input wire logic [7:0] mem_rdata_i,
  input wire ido_pkg::ido_bus_s mem_bus_o,
  input wire ido_pkg::ido_regs_s regs_o,
  input wire logic instr_done_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // operand steps on the direct page
  sequence page_read;
    mem_bus_o.re && mem_bus_o.addr[15:8] == ido_pkg::DIRECT_PAGE;
  endsequence
  sequence first_write;
    mem_bus_o.we && !instr_done_o;
  endsequence
  next_fetch_a:
    assert property (instr_done_o |=> mem_bus_o.re && mem_bus_o.addr == regs_o.pc)
    else $error("opcode fetch not at pc");
  write_page_a:
    assert property ($rose(mem_bus_o.we) |-> mem_bus_o.addr[15:8] == ido_pkg::DIRECT_PAGE)
    else $error("write outside direct page");
  pair_write_a:
    assert property (first_write |-> mem_bus_o.wdata == regs_o.hx[15:8] ##1 mem_bus_o.we
      && mem_bus_o.addr == $past(mem_bus_o.addr) + ido_pkg::ADDR_STEP
      && mem_bus_o.wdata == regs_o.hx[7:0])
    else $error("pair store order wrong");
  write_burst_a:
    assert property (mem_bus_o.we ##1 mem_bus_o.we |=> !mem_bus_o.we)
    else $error("more than two bytes written");
  pair_read_a:
    assert property (page_read ##1 page_read |->
      mem_bus_o.addr == $past(mem_bus_o.addr) + ido_pkg::ADDR_STEP)
    else $error("pair read not at address plus one");
  regs_hold_a:
    assert property (!instr_done_o |=> $stable(regs_o.hx) && $stable(regs_o.sp)
      && $stable(regs_o.acc))
    else $error("register moved inside instruction");
  done_space_a:
    assert property (instr_done_o |=> !instr_done_o ##[1:6] instr_done_o)
    else $error("instruction length out of range");
  write_alone_a:
    assert property (mem_bus_o.we |-> !mem_bus_o.re)
    else $error("write overlaps read");
endmodule : ido_core_props
bind ido_core ido_core_props ido_core_props_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
  .mem_rdata_i(mem_rdata_i), .mem_bus_o(mem_bus_o), .regs_o(regs_o),
  .instr_done_o(instr_done_o));
`default_nettype wire

// ---- tb/ido_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ido_mem_model (
  // clock
  input wire logic sys_clk_i,
  // bus from the core
  input wire ido_pkg::ido_bus_s bus_i,
  // read data, one cycle after its address
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  // empty space holds a one-byte skip so a run-on program stays bounded
  initial
  begin
    for (int k = 0; k < 65536; k++)
      mem[k] = 8'h9D;
  end
  // without a read strobe show the inverse byte, so stale data never passes
  always @(posedge sys_clk_i)
  begin
    if (bus_i.we)
      mem[bus_i.addr] <= bus_i.wdata;
    rdata_o <= bus_i.re ? mem[bus_i.addr] : ~rdata_o;
  end
endmodule : ido_mem_model
`default_nettype wire
